// ---- rtl/psar_pkg.sv ----
// Constants and types for the coding sublayer status and ability register bank
// Operation
// [RL1] Status bit 0 reads one: extended registers
// [RL2] Status bits 1, 4, 6, 8 read zero
// [RL3] Link bit one when valid, latches zero
// [RL4] Status bit 3 reads one: negotiation supported
// [RL5] Status bit 5 shows negotiation complete
// [RL6] Status bit 7 reads one: unidirectional transmit
// [RL7] Status bits 9 to 15 read zero
// [RL8] Software trusts ability words only when complete
// [RL9] Local and peer words share one layout
// [RL10] Software writes zero to reserved ability bits
// [RL11] Bit 5 full duplex, bit 6 half
// [RL12] Bits 7, 8 encode pause capability
// [RL13] Bits 12, 13 encode remote fault
// [RL14] Ack bit set after three matching words
// [RL15] Local next-page bit always zero
// [RL16] Local ability word is read and write
// [RL17] Peer ability word is read only
// [RL18] Writes to status and peer ignored
package psar_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	// Word offsets of the register map
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h01;
	localparam logic [ADDR_W-1:0] OFS_LOCAL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_PEER = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h09;
	// Status bit positions
	localparam int ST_EXT = 0;
	localparam int ST_LINK = 2;
	localparam int ST_AN_ABLE = 3;
	localparam int ST_AN_DONE = 5;
	localparam int ST_UNIDIR = 7;
	// Ability word bit positions
	localparam int AB_FD = 5;
	localparam int AB_HD = 6;
	localparam int AB_PS_LO = 7;
	localparam int AB_PS_HI = 8;
	localparam int AB_RF_LO = 12;
	localparam int AB_RF_HI = 13;
	localparam int AB_ACK = 14;
	localparam int AB_NP = 15;
	// Event bits of the interrupt status register
	localparam int IRQ_N = 3;
	localparam int EV_LINK_LOST = 0;
	localparam int EV_AN_DONE = 1;
	localparam int EV_PAGE = 2;
	// Reset values
	localparam logic [DATA_W-1:0] LOCAL_RESET = 16'h01A0;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [IRQ_N-1:0] IRQ_ZERO = 3'h0;
	// Consecutive matches needed before acknowledging
	localparam int MATCH_NEED = 3;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} psar_req_t;
	// Ability word received from the link partner
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] word;
	} psar_rx_t;
	// Fields of an ability word, shared by local and peer
	typedef struct packed {
		logic full_duplex_capable;
		logic half_duplex_capable;
		logic pause_bit_a;
		logic pause_bit_b;
		logic fault_code_bit_a;
		logic fault_code_bit_b;
		logic ack;
		logic more_pages_flag;
	} psar_fields_t;
	// Gray-coded match tracker
	typedef enum logic [1:0] {
		M_NONE = 2'b00,
		M_ONE = 2'b01,
		M_TWO = 2'b11,
		M_ACKED = 2'b10
	} psar_match_t;
endpackage : psar_pkg

// ---- rtl/psar_regs.sv ----
// Status and ability register bank with event interrupt
`timescale 1ns/1ns
module psar_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire psar_pkg::psar_req_t req,
	output logic [psar_pkg::DATA_W-1:0] rdata,
	input wire logic link_ok,
	input wire logic an_done,
	input wire logic an_restart,
	input wire psar_pkg::psar_rx_t rx_ability,
	output logic [psar_pkg::DATA_W-1:0] tx_ability,
	output psar_pkg::psar_fields_t peer_fields,
	output logic irq
);
	import psar_pkg::*;

	// Pulls the named fields out of an ability word
	function automatic psar_fields_t unpack_fields(input logic [DATA_W-1:0] w);
		psar_fields_t f;
		f.full_duplex_capable = w[AB_FD];
		f.half_duplex_capable = w[AB_HD];
		f.pause_bit_a = w[AB_PS_LO];
		f.pause_bit_b = w[AB_PS_HI];
		f.fault_code_bit_a = w[AB_RF_LO];
		f.fault_code_bit_b = w[AB_RF_HI];
		f.ack = w[AB_ACK];
		f.more_pages_flag = w[AB_NP];
		return f;
	endfunction : unpack_fields

	logic link_latch;
	logic an_done_q;
	logic [DATA_W-1:0] local_store;
	logic [DATA_W-1:0] peer_word;
	logic [DATA_W-1:0] last_rx;
	psar_match_t match_state;
	psar_match_t next_match;
	logic [IRQ_N-1:0] irq_stat;
	logic [IRQ_N-1:0] irq_mask;

	// Address decode
	wire sel_status = req.addr == OFS_STATUS;
	wire sel_local = req.addr == OFS_LOCAL;
	wire sel_peer = req.addr == OFS_PEER;
	wire sel_istat = req.addr == OFS_IRQ_STAT;
	wire sel_imask = req.addr == OFS_IRQ_MASK;
	wire rd_status = req.rd & sel_status;
	wire rd_istat = req.rd & sel_istat;
	// Only the local word and the mask take writes; status and peer drop them
	wire wr_local = req.wr & sel_local; // [RL16] [RL18]
	wire wr_imask = req.wr & sel_imask;

	// Acknowledge follows the match tracker
	wire ack_set = match_state == M_ACKED; // [RL14]
	wire rx_same = rx_ability.word == last_rx;

	// Local word as read and sent: next page forced low, ack from tracker
	wire [DATA_W-1:0] local_word = {1'b0, ack_set, local_store[AB_RF_HI:0]}; // [RL15] [RL14]

	// Status word; constant bits per capability, unused bits zero
	wire [DATA_W-1:0] status_word = {
		8'h00, // [RL7] [RL2]
		1'b1, // [RL6]
		1'b0, // [RL2]
		an_done, // [RL5]
		1'b0, // [RL2]
		1'b1, // [RL4]
		link_latch, // [RL3]
		1'b0, // [RL2]
		1'b1 // [RL1]
	};

	// Events that feed the sticky interrupt bits
	wire ev_link_lost = link_latch & ~link_ok;
	wire ev_an_done = an_done & ~an_done_q;
	wire ev_page = rx_ability.valid & (next_match == M_ACKED) & ~ack_set;
	wire [IRQ_N-1:0] events = {ev_page, ev_an_done, ev_link_lost};

	// Read data mux, unmapped addresses read zero
	wire [DATA_W-1:0] next_rdata =
		sel_status ? status_word :
		sel_local ? local_word :
		sel_peer ? peer_word :
		sel_istat ? {13'h0000, irq_stat} :
		sel_imask ? {13'h0000, irq_mask} : WORD_ZERO;

	// Level interrupt from unmasked sticky bits
	assign irq = |(irq_stat & irq_mask);
	// Same layout drives both directions
	assign tx_ability = local_word; // [RL9]
	assign peer_fields = unpack_fields(peer_word); // [RL9] [RL11] [RL12] [RL13]

	// Match tracker: three equal words in a row earn the ack
	always_comb
	begin
		next_match = match_state;
		if (an_restart)
			next_match = M_NONE;
		else if (rx_ability.valid)
		begin
			case (match_state)
				M_NONE: next_match = M_ONE;
				M_ONE: next_match = rx_same ? M_TWO : M_ONE;
				M_TWO: next_match = rx_same ? M_ACKED : M_ONE;
				M_ACKED: next_match = rx_same ? M_ACKED : M_ONE; // [RL14]
				default: next_match = M_NONE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			match_state <= M_NONE;
			last_rx <= WORD_ZERO;
		end
		else
		begin
			match_state <= next_match;
			if (rx_ability.valid)
				last_rx <= rx_ability.word;
		end
	end

	// Peer word only ever loads from the link, never from software
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			peer_word <= WORD_ZERO;
		else if (ev_page)
			peer_word <= rx_ability.word; // [RL17]
	end

	// Latch-low link: a read reloads it from the live level
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			link_latch <= 1'b0;
		else if (rd_status)
			link_latch <= link_ok; // [RL3]
		else
			link_latch <= link_latch & link_ok; // [RL3]
	end

	// Software-owned local word and mask
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			local_store <= LOCAL_RESET;
			irq_mask <= IRQ_ZERO;
		end
		else
		begin
			if (wr_local)
				local_store <= req.wdata; // [RL16]
			if (wr_imask)
				irq_mask <= req.wdata[IRQ_N-1:0];
		end
	end

	// Sticky events; a new event beats a read clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			irq_stat <= IRQ_ZERO;
			an_done_q <= 1'b0;
		end
		else
		begin
			irq_stat <= (rd_istat ? IRQ_ZERO : irq_stat) | events;
			an_done_q <= an_done;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rdata <= WORD_ZERO;
		else if (req.rd)
			rdata <= next_rdata;
		else
			rdata <= WORD_ZERO;
	end

	// Checks on the status constants and latches
	AST_EXT_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
		rd_status |=> rdata[ST_EXT])
		else $error("extended capability bit not one");
	AST_ZERO_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL2]
		rd_status |=> !rdata[1] && !rdata[4] && !rdata[6] && !rdata[8])
		else $error("unused status bit not zero");
	AST_LINK_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		(!link_ok && !rd_status) ##1 rd_status |=> !rdata[ST_LINK])
		else $error("link loss not latched");
	AST_LINK_UP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		(rd_status && link_ok) ##1 (link_ok && rd_status) |=> rdata[ST_LINK])
		else $error("valid link not reported");
	AST_AN_ABLE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL4]
		rd_status |=> rdata[ST_AN_ABLE])
		else $error("negotiation ability not one");
	AST_AN_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL5]
		rd_status |=> rdata[ST_AN_DONE] == $past(an_done))
		else $error("negotiation complete bit wrong");
	AST_UNIDIR: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
		rd_status |=> rdata[ST_UNIDIR])
		else $error("unidirectional bit not one");
	AST_HIGH_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL7]
		rd_status |=> rdata[15:9] == 7'h00)
		else $error("upper status bits not zero");

	// Checks on the ability words
	AST_LOCAL_NP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL15]
		!tx_ability[AB_NP])
		else $error("local next page set");
	AST_LOCAL_WR: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL16]
		wr_local ##1 (req.rd && sel_local && !req.wr) |=> rdata[AB_RF_HI:0] == $past(req.wdata[AB_RF_HI:0], 2))
		else $error("local word write lost");
	AST_PEER_RO: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL17]
		(req.wr && sel_peer && !ev_page) |=> $stable(peer_word))
		else $error("peer word changed by write");
	AST_ACK: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		(rx_ability.valid && !an_restart && match_state == M_TWO && rx_same) |=> tx_ability[AB_ACK])
		else $error("ack not set after three matches");
	AST_NO_EARLY_ACK: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		an_restart |=> !tx_ability[AB_ACK])
		else $error("ack held across restart");
	AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ev_link_lost && irq_mask[EV_LINK_LOST]) |=> irq)
		else $error("unmasked event missed the interrupt");

	// Checks on the read port; every answer stands for one cycle only
	AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!req.rd |=> rdata == WORD_ZERO)
		else $error("read data not zero outside a read");
	AST_RD_LOCAL: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL16]
		(req.rd && sel_local) |=> rdata == $past(local_word))
		else $error("local word read wrong");
	AST_RD_PEER: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL17]
		(req.rd && sel_peer) |=> rdata == $past(peer_word))
		else $error("peer word read wrong");
	AST_RD_ISTAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_istat |=> rdata[IRQ_N-1:0] == $past(irq_stat) && rdata[DATA_W-1:IRQ_N] == '0)
		else $error("interrupt status read wrong");
	AST_RD_IMASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && sel_imask) |=> rdata[IRQ_N-1:0] == $past(irq_mask) && rdata[DATA_W-1:IRQ_N] == '0)
		else $error("interrupt mask read wrong");
	AST_RD_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && !sel_status && !sel_local && !sel_peer && !sel_istat && !sel_imask) |=> rdata == WORD_ZERO)
		else $error("unmapped read not zero");
	AST_STATUS_LINK: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		rd_status |=> rdata[ST_LINK] == $past(link_latch))
		else $error("status read does not show the latched link");

	// Checks on the link latch and on write protection
	AST_LINK_FALL: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		(!link_ok && !rd_status) |=> !link_latch)
		else $error("link loss not captured");
	AST_LINK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		(!link_latch && !rd_status) |=> !link_latch)
		else $error("latched link loss released without a read");
	AST_LINK_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
		rd_status |=> link_latch == $past(link_ok))
		else $error("status read did not reload the link latch");
	AST_LOCAL_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL18]
		!wr_local |=> $stable(local_store))
		else $error("local word changed without a write to it");
	AST_MASK_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!wr_imask |=> $stable(irq_mask))
		else $error("mask changed without a write to it");
	AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_imask |=> irq_mask == $past(req.wdata[IRQ_N-1:0]))
		else $error("mask write lost");

	// Checks on the advertised word and the captured peer fields
	AST_LOCAL_TX: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL16]
		wr_local |=> tx_ability[AB_RF_HI:0] == $past(req.wdata[AB_RF_HI:0]))
		else $error("written local word not advertised");
	AST_PEER_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL17]
		!ev_page |=> $stable(peer_word))
		else $error("peer word changed without a page");
	AST_PEER_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL17]
		ev_page |=> peer_word == $past(rx_ability.word))
		else $error("peer word not loaded from the link");
	AST_PEER_DUPLEX: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL11]
		ev_page |=> peer_fields.full_duplex_capable == $past(rx_ability.word[AB_FD])
			&& peer_fields.half_duplex_capable == $past(rx_ability.word[AB_HD]))
		else $error("duplex fields misplaced");
	AST_PEER_PAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL12]
		ev_page |=> peer_fields.pause_bit_a == $past(rx_ability.word[AB_PS_LO])
			&& peer_fields.pause_bit_b == $past(rx_ability.word[AB_PS_HI]))
		else $error("pause fields misplaced");
	AST_PEER_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL13]
		ev_page |=> peer_fields.fault_code_bit_a == $past(rx_ability.word[AB_RF_LO])
			&& peer_fields.fault_code_bit_b == $past(rx_ability.word[AB_RF_HI]))
		else $error("fault fields misplaced");
	AST_PEER_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL9]
		ev_page |=> peer_fields.ack == $past(rx_ability.word[AB_ACK])
			&& peer_fields.more_pages_flag == $past(rx_ability.word[AB_NP]))
		else $error("top fields misplaced");

	// Checks on the acknowledge tracker and the sticky interrupt bits
	AST_ACK_MISS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		(rx_ability.valid && !an_restart && !rx_same) |=> !tx_ability[AB_ACK])
		else $error("ack kept after a differing word");
	AST_ACK_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		(!rx_ability.valid && !an_restart) |=> $stable(tx_ability[AB_ACK]))
		else $error("ack moved without a received word");
	AST_ACK_EARLY: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		(match_state == M_NONE || match_state == M_ONE) |=> !tx_ability[AB_ACK])
		else $error("ack before three matching words");
	AST_ACK_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		(ack_set && rx_ability.valid && rx_same && !an_restart) |=> tx_ability[AB_ACK])
		else $error("ack dropped on a matching word");
	AST_PAGE_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
		ev_page |=> !ev_page)
		else $error("page event repeated");
	AST_PAGE_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ev_page |=> irq_stat[EV_PAGE])
		else $error("page event not recorded");
	AST_AN_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ev_an_done |=> irq_stat[EV_AN_DONE])
		else $error("completion event not recorded");
	AST_LINK_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ev_link_lost |=> irq_stat[EV_LINK_LOST])
		else $error("link loss event not recorded");
	AST_IRQ_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!rd_istat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
		else $error("sticky bit lost without a read");
	AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_istat && events == IRQ_ZERO) |=> irq_stat == IRQ_ZERO)
		else $error("status read did not clear");
	AST_IRQ_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_istat |=> (irq_stat & $past(events)) == $past(events))
		else $error("event lost to a read clear");

	// Main scenarios
	COV_ACK: cover property (@(posedge ref_clk) disable iff (!rst_n)
		match_state == M_TWO ##1 match_state == M_ACKED);
	COV_LINK_DROP: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ev_link_lost ##[1:20] rd_status);
	COV_IRQ_CLEAR: cover property (@(posedge ref_clk) disable iff (!rst_n)
		irq ##1 rd_istat ##1 !irq);
	COV_LOCAL_RW: cover property (@(posedge ref_clk) disable iff (!rst_n)
		wr_local ##1 (req.rd && sel_local));
endmodule : psar_regs

// ---- sim/psar_regs_test.sv ----
// Self-checking bench for the status and ability register bank
`timescale 1ns/1ns
module psar_regs_test;
	import psar_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	psar_req_t req = '0;
	psar_rx_t rx = '0;
	logic link_ok = 1'b0;
	logic an_done = 1'b0;
	logic an_restart = 1'b0;
	logic [15:0] rdata;
	logic [15:0] tx_ability;
	psar_fields_t peer_fields;
	logic irq;
	logic [15:0] w;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	psar_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .link_ok(link_ok),
		.an_done(an_done), .an_restart(an_restart), .rx_ability(rx), .tx_ability(tx_ability),
		.peer_fields(peer_fields), .irq(irq));
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	// Hang guard, far above the roughly 125 cycles the run needs
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask : wr
	// Data is only valid in the cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	// Same word on three consecutive edges
	task automatic send3(input logic [15:0] d);
		@(posedge ref_clk);
		rx <= '{valid: 1'b1, word: d};
		repeat (3) @(posedge ref_clk);
		rx.valid <= 1'b0;
	endtask : send3
	task automatic restart();
		@(posedge ref_clk);
		an_restart <= 1'b1;
		@(posedge ref_clk);
		an_restart <= 1'b0;
	endtask : restart
	task automatic t_reset();
		#1 chk(tx_ability, LOCAL_RESET);
		chk({15'h0000, irq}, 16'h0000);
		rd_chk(OFS_STATUS, 16'h0089);
		rd_chk(OFS_LOCAL, LOCAL_RESET);
	endtask : t_reset
	task automatic t_link();
		@(posedge ref_clk);
		link_ok <= 1'b1;
		rd_chk(OFS_STATUS, 16'h0089);
		rd_chk(OFS_STATUS, 16'h008D);
		@(posedge ref_clk);
		an_done <= 1'b1;
		rd_chk(OFS_STATUS, 16'h00AD);
		@(posedge ref_clk);
		link_ok <= 1'b0;
		@(posedge ref_clk);
		link_ok <= 1'b1;
		rd_chk(OFS_STATUS, 16'h00A9);
		rd_chk(OFS_STATUS, 16'h00AD);
	endtask : t_link
	task automatic t_write();
		wr(OFS_LOCAL, 16'hF1E0);
		rd_chk(OFS_LOCAL, 16'h31E0);
		chk(tx_ability, 16'h31E0);
		wr(OFS_STATUS, 16'h0000);
		rd_chk(OFS_STATUS, 16'h00AD);
		wr(OFS_PEER, 16'hF1E0);
		rd_chk(OFS_PEER, 16'h0000);
		wr(5'h1F, 16'hF1E0);
		rd_chk(5'h1F, 16'h0000);
	endtask : t_write
	// Back-to-back strobes: write then read, then two status reads in a row
	task automatic t_b2b();
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: OFS_LOCAL, wdata: 16'h2160};
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: OFS_LOCAL, wdata: 16'h0000};
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: OFS_STATUS, wdata: 16'h0000};
		#1 chk(rdata, 16'h2160);
		@(posedge ref_clk);
		#1 chk(rdata, 16'h00AD);
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1 chk(rdata, 16'h00AD);
		@(posedge ref_clk);
		#1 chk(rdata, 16'h0000);
	endtask : t_b2b
	// Events: pending bits read and cleared, unmasked link loss raises the line
	task automatic t_irq();
		chk({15'h0000, irq}, 16'h0000);
		rd_chk(OFS_IRQ_STAT, 16'h0003);
		rd_chk(OFS_IRQ_STAT, 16'h0000);
		wr(OFS_IRQ_MASK, 16'h0001);
		@(posedge ref_clk);
		link_ok <= 1'b0;
		@(posedge ref_clk);
		link_ok <= 1'b1;
		#1 chk({15'h0000, irq}, 16'h0001);
		rd_chk(OFS_IRQ_STAT, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		wr(OFS_IRQ_MASK, 16'h0004);
		rd_chk(OFS_IRQ_MASK, 16'h0004);
	endtask : t_irq
	// Every pause and fault code, decoded from the peer word
	task automatic t_abil();
		for (int i = 0; i < 4; i++)
		begin
			w = {i[0], 1'b0, i[1], i[0], 3'b000, i[0], i[1], i[1] & i[0], 1'b1, 5'h00};
			restart();
			send3(w);
			#1 chk(tx_ability, 16'h6160);
			@(posedge ref_clk);
			#1 chk({8'h00, peer_fields}, {8'h00, w[5], w[6], w[7], w[8], w[12], w[13], w[14], w[15]});
			rd_chk(OFS_PEER, w);
			chk({15'h0000, irq}, 16'h0001);
			rd_chk(OFS_IRQ_STAT, 16'h0004);
			chk({15'h0000, irq}, 16'h0000);
		end
		// Third word differs, so no acknowledge
		restart();
		@(posedge ref_clk);
		rx <= '{valid: 1'b1, word: 16'h0020};
		repeat (2) @(posedge ref_clk);
		rx.word <= 16'h0040;
		@(posedge ref_clk);
		rx.valid <= 1'b0;
		#1 chk(tx_ability, 16'h2160);
		chk({15'h0000, irq}, 16'h0000);
	endtask : t_abil
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_link();
		t_write();
		t_b2b();
		t_irq();
		t_abil();
		close_out();
	end
endmodule : psar_regs_test
